// ===== hdl/wkt_sync.sv
// wkt_sync: three-stage synchroniser with agreement filter for one pin level
// assumes the input is asynchronous to mclk; output changes once stages 2 and 3 agree
`timescale 1ns/1ps
`default_nettype none
module wkt_sync (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // pin level in, filtered level out
  input  wire logic pin_in,
  output var  logic level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // stage 1 feeds only stage 2
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only when the two later stages agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end
endmodule : wkt_sync
`default_nettype wire

// ===== hdl/wkt_top.sv
// wkt_top: 16-bit down-counting wake-up timer on the low-frequency oscillator
// assumes lfo, card-detect results and probe-done arrive asynchronously on pins
// What this block does
// - control bit 7 shows whether the timer counts; writes start or stop it
// - running bit changes on write only when permit bit 6 is set too
// - with calibrate enabled, every underflow pulses the oscillator trimming start
// - with card probing enabled, every underflow starts a card detection sequence
// - card found raises interrupt, if enabled, and keeps chip active
// - no card found enters power down when that is enabled
// - during card probing the timer restarts at once after underflow
// - field stays on for the field-on timer's period during detection
// - auto-reload reloads and continues at zero; otherwise counts to zero, stops
// - every underflow sets the wake timer interrupt flag
// - with auto-wake enabled, underflow brings the chip out of power down
// - tick source selects oscillator divided by 1, 8, 16 or 32
// - each start event loads counter from the 16-bit reload value
// - reload byte writes leave a running count alone until next start or underflow reload
// - live counter readable as read-only high and low bytes
// - reload high, low, then counter high, low at consecutive addresses
`timescale 1ns/1ps
`default_nettype none
module wkt_top
  import wkt_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata_q,
  // oscillator and detection pins
  input  wire logic       lfo_clk_pin,
  input  wire logic       card_found_pin,
  input  wire logic       probe_done_pin,
  // system control outputs
  output var  logic       trim_start_q,
  output var  logic       probe_start_q,
  output var  logic       field_on_q,
  output var  logic       wake_q,
  output var  logic       power_down_q,
  output var  logic       irq_q
);

  logic [7:0]  ctrl_q;        // bits 5..0 stored, bits 7..6 held zero; read bit 7 comes from active_q
  logic        active_q;
  logic [15:0] reload_q;
  logic [15:0] count_q;
  logic [4:0]  pre_q;
  logic [4:0]  pre_max;
  logic [WKT_ST_WIDTH-1:0] status_q;
  logic [WKT_ST_WIDTH-1:0] mask_q;
  logic        lfo_lvl;
  logic        card_lvl;
  logic        done_lvl;
  logic        lfo_prev_q;
  logic        done_prev_q;
  logic        lfo_rise;
  logic        done_rise;
  logic        tick;
  logic        underflow;
  logic        start_evt;
  logic        stop_evt;
  logic        wr_ctrl;
  logic        rd_status;
  logic        probe_ends;
  wkt_probe_t  probe_q;

  // pins pass the three-stage agreement filter
  wkt_sync u_sync_lfo (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .pin_in  (lfo_clk_pin),
    .level_q (lfo_lvl)
  );
  wkt_sync u_sync_card (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .pin_in  (card_found_pin),
    .level_q (card_lvl)
  );
  wkt_sync u_sync_done (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .pin_in  (probe_done_pin),
    .level_q (done_lvl)
  );

  // edge detectors look only at filtered levels
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lfo_prev_q  <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      lfo_prev_q  <= lfo_lvl;
      done_prev_q <= done_lvl;
    end
  end

  assign lfo_rise  = lfo_lvl & ~lfo_prev_q;
  assign done_rise = done_lvl & ~done_prev_q;
  assign wr_ctrl   = reg_wr && (reg_addr == WKT_ADDR_CONTROL);
  assign rd_status = reg_rd && (reg_addr == WKT_ADDR_STATUS);

  // host start/stop, honoured only with the permit bit in the same write
  assign start_evt = wr_ctrl && reg_wdata[WKT_BIT_PERMIT] && reg_wdata[WKT_BIT_ACTIVE];
  assign stop_evt  = wr_ctrl && reg_wdata[WKT_BIT_PERMIT] && !reg_wdata[WKT_BIT_ACTIVE];

  // prescaler terminal count from tick source select
  // a change of tick source takes hold at once; software should
  // stop the timer first if the running period must stay exact
  always_comb begin
    case (ctrl_q[WKT_BIT_TICK_HI:WKT_BIT_TICK_LO])
      2'b00:   pre_max = WKT_DIV_1;
      2'b01:   pre_max = WKT_DIV_8;
      2'b10:   pre_max = WKT_DIV_16;
      2'b11:   pre_max = WKT_DIV_32;
      default: pre_max = WKT_DIV_1;
    endcase
  end

  assign tick      = active_q && lfo_rise && (pre_q >= pre_max);
  assign underflow = tick && (count_q == WKT_RST_COUNT);

  // prescaler restarts with each start so the first period is whole
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 5'h00;
    end else if (start_evt || !active_q) begin
      pre_q <= 5'h00;
    end else if (lfo_rise) begin
      pre_q <= (pre_q >= pre_max) ? 5'h00 : pre_q + 5'h01;
    end
  end

  // stored control bits; the permit bit is write-only and reads zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= WKT_RST_BYTE;
    end else if (wr_ctrl) begin
      ctrl_q <= {2'b00, reg_wdata[WKT_BIT_CALIBRATE:WKT_BIT_TICK_LO]};
    end
  end

  // running state: host start/stop, stop at zero without reload or card probing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
    end else if (start_evt) begin
      active_q <= 1'b1;
    end else if (stop_evt) begin
      active_q <= 1'b0;
    end else if (underflow && !ctrl_q[WKT_BIT_RELOAD] && !ctrl_q[WKT_BIT_PROBE]) begin
      active_q <= 1'b0;
    end
  end

  // reload bytes are only copied into the counter at a start event or at an underflow with reload or probing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reload_q <= WKT_RST_COUNT;
    end else if (reg_wr && reg_addr == WKT_ADDR_RELOAD_H) begin
      reload_q[15:8] <= reg_wdata;
    end else if (reg_wr && reg_addr == WKT_ADDR_RELOAD_L) begin
      reload_q[7:0] <= reg_wdata;
    end
  end

  // counter: load at start and at reload, decrement per tick
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= WKT_RST_COUNT;
    end else if (start_evt) begin
      count_q <= reload_q;
    end else if (underflow) begin
      // card probing restarts with no gap, as auto-reload does
      if (ctrl_q[WKT_BIT_RELOAD] || ctrl_q[WKT_BIT_PROBE]) begin
        count_q <= reload_q;
      end
    end else if (tick) begin
      count_q <= count_q - 16'h0001;
    end
  end

  // one-cycle start pulses to the trimming and detection procedures
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trim_start_q  <= 1'b0;
      probe_start_q <= 1'b0;
    end else begin
      trim_start_q  <= underflow && ctrl_q[WKT_BIT_CALIBRATE];
      probe_start_q <= underflow && ctrl_q[WKT_BIT_PROBE];
    end
  end

  // detection sequencer: field on until the field-on timer reports done
  // a stop written mid-probe leaves the sequence to finish on its own
  assign probe_ends = (probe_q == WKT_PROBE_FIELD) && done_rise;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      probe_q <= WKT_PROBE_IDLE;
    end else begin
      case (probe_q)
        WKT_PROBE_IDLE:  if (underflow && ctrl_q[WKT_BIT_PROBE]) probe_q <= WKT_PROBE_FIELD;
        WKT_PROBE_FIELD: if (done_rise) probe_q <= WKT_PROBE_DONE;
        WKT_PROBE_DONE:  probe_q <= WKT_PROBE_IDLE;
        default:         probe_q <= WKT_PROBE_IDLE;
      endcase
    end
  end

  // field output follows the sequencer state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      field_on_q <= 1'b0;
    end else begin
      field_on_q <= (probe_q == WKT_PROBE_FIELD) && !done_rise;
    end
  end

  // power state: wake on underflow, sleep again after a fruitless probe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      power_down_q <= 1'b0;
      wake_q       <= 1'b0;
    end else begin
      wake_q <= underflow && ctrl_q[WKT_BIT_WAKE];
      if (underflow && ctrl_q[WKT_BIT_WAKE]) begin
        power_down_q <= 1'b0;
      end else if (probe_ends && !card_lvl && ctrl_q[WKT_BIT_WAKE]) begin
        power_down_q <= 1'b1;
      end else if (probe_ends && card_lvl) begin
        power_down_q <= 1'b0;
      end
    end
  end

  // sticky status: a new event wins over the read that clears it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= WKT_RST_STATUS;
    end else begin
      status_q <= (rd_status ? WKT_RST_STATUS : status_q) |
                  {probe_ends && !card_lvl,
                   probe_ends && card_lvl,
                   underflow};
    end
  end

  // interrupt mask
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= WKT_RST_STATUS;
    end else if (reg_wr && reg_addr == WKT_ADDR_MASK) begin
      mask_q <= reg_wdata[WKT_ST_WIDTH-1:0];
    end
  end

  // level interrupt, one cycle behind the status register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  // read data one cycle after the strobe, zero otherwise and for unmapped addresses
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= WKT_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        WKT_ADDR_CONTROL:  reg_rdata_q <= {active_q, 1'b0, ctrl_q[5:0]};
        WKT_ADDR_RELOAD_H: reg_rdata_q <= reload_q[15:8];
        WKT_ADDR_RELOAD_L: reg_rdata_q <= reload_q[7:0];
        WKT_ADDR_COUNT_H:  reg_rdata_q <= count_q[15:8];
        WKT_ADDR_COUNT_L:  reg_rdata_q <= count_q[7:0];
        WKT_ADDR_STATUS:   reg_rdata_q <= {5'h00, status_q};
        WKT_ADDR_MASK:     reg_rdata_q <= {5'h00, mask_q};
        default:           reg_rdata_q <= WKT_RST_BYTE;
      endcase
    end else begin
      reg_rdata_q <= WKT_RST_BYTE;
    end
  end

endmodule : wkt_top
`default_nettype wire

// ===== shared/wkt_pkg.sv
// wkt_pkg: register map, field positions, reset values and codes of the wake-up timer
// assumes an 8-bit register port with byte-wide registers at the offsets below
package wkt_pkg;

  // register offsets
  localparam logic [7:0] WKT_ADDR_CONTROL  = 8'h23;
  localparam logic [7:0] WKT_ADDR_RELOAD_H = 8'h24;
  localparam logic [7:0] WKT_ADDR_RELOAD_L = 8'h25;
  localparam logic [7:0] WKT_ADDR_COUNT_H  = 8'h26;
  localparam logic [7:0] WKT_ADDR_COUNT_L  = 8'h27;
  localparam logic [7:0] WKT_ADDR_STATUS   = 8'h2e;
  localparam logic [7:0] WKT_ADDR_MASK     = 8'h2f;

  // control register fields
  localparam int WKT_BIT_ACTIVE    = 7;
  localparam int WKT_BIT_PERMIT    = 6;
  localparam int WKT_BIT_CALIBRATE = 5;
  localparam int WKT_BIT_PROBE     = 4;
  localparam int WKT_BIT_RELOAD    = 3;
  localparam int WKT_BIT_WAKE      = 2;
  localparam int WKT_BIT_TICK_HI   = 1;
  localparam int WKT_BIT_TICK_LO   = 0;

  // status / mask register fields
  localparam int WKT_ST_UNDERFLOW  = 0;
  localparam int WKT_ST_CARD       = 1;
  localparam int WKT_ST_NO_CARD    = 2;
  localparam int WKT_ST_WIDTH      = 3;

  // reset values
  localparam logic [7:0]  WKT_RST_BYTE   = 8'h00;
  localparam logic [15:0] WKT_RST_COUNT  = 16'h0000;
  localparam logic [2:0]  WKT_RST_STATUS = 3'h0;

  // prescaler terminal counts: divide by 1, 8, 16, 32
  localparam logic [4:0] WKT_DIV_1  = 5'h00;
  localparam logic [4:0] WKT_DIV_8  = 5'h07;
  localparam logic [4:0] WKT_DIV_16 = 5'h0f;
  localparam logic [4:0] WKT_DIV_32 = 5'h1f;

  // card probe sequencer
  typedef enum logic [1:0] {
    WKT_PROBE_IDLE  = 2'b00,
    WKT_PROBE_FIELD = 2'b01,
    WKT_PROBE_DONE  = 2'b10
  } wkt_probe_t;

endpackage : wkt_pkg

// ===== test/tb_wkt_top.sv
// tb_wkt_top: self-checking bench for the wake-up timer
// assumes the bench alone drives registers, oscillator and detection pins
`timescale 1ns/1ps
`default_nettype none
module tb_wkt_top;
  import wkt_pkg::*;
  logic             mclk, rst_n, reg_wr, reg_rd, low_freq_oscillator, card, done, rd_prev;
  logic [7:0]       addr, wdata;
  logic [15:0]      r;
  logic [7:0]       exp_q[$];
  wire logic [7:0]  rdata;
  wire logic        trim, probe, field, wake, pd, irq;
  int               errors, samples_checked, n_trim, n_probe, n_wake, div;
  wkt_top dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata), .lfo_clk_pin(low_freq_oscillator),
    .card_found_pin(card), .probe_done_pin(done), .trim_start_q(trim),
    .probe_start_q(probe), .field_on_q(field), .wake_q(wake), .power_down_q(pd), .irq_q(irq));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  // expected data queued here, compared by the monitor a cycle later
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask : rd
  // oscillator runs only inside this task so counts stay exact
  task automatic ticks(int n);
    repeat (n) begin
      repeat (10) @(posedge mclk);
      low_freq_oscillator <= 1'b1;
      repeat (10) @(posedge mclk);
      low_freq_oscillator <= 1'b0;
    end
    repeat (8) @(posedge mclk);
  endtask : ticks
  always @(posedge mclk) rd_prev <= reg_rd;
  always @(negedge mclk) if (rd_prev) chk("read data", exp_q.pop_front(), rdata);
  // pulse counters; a stuck pulse shows as an overcount
  always @(posedge mclk) begin
    n_trim += (trim === 1'b1);
    n_probe += (probe === 1'b1);
    n_wake += (wake === 1'b1);
  end
  initial begin
    #2_000_000;
    errors++;
    give_verdict();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, low_freq_oscillator, card, done} = 6'h00;
    {addr, wdata} = 16'h0000;
    void'($urandom(32'h7610));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int a = 8'h22; a <= 8'h30; a++) rd(8'(a), 8'h00);
    wr(WKT_ADDR_COUNT_H, 8'hff);
    rd(WKT_ADDR_COUNT_H, 8'h00);
    r = 16'($urandom()) | 16'h0100;
    wr(WKT_ADDR_RELOAD_H, r[15:8]);
    wr(WKT_ADDR_RELOAD_L, r[7:0]);
    rd(WKT_ADDR_RELOAD_H, r[15:8]);
    wr(WKT_ADDR_CONTROL, 8'h88);
    rd(WKT_ADDR_CONTROL, 8'h08);
    wr(WKT_ADDR_CONTROL, 8'hc8);
    rd(WKT_ADDR_CONTROL, 8'h88);
    rd(WKT_ADDR_COUNT_H, r[15:8]);
    rd(WKT_ADDR_COUNT_L, r[7:0]);
    wr(WKT_ADDR_RELOAD_L, ~r[7:0]);
    ticks(3);
    r = r - 16'd3;
    rd(WKT_ADDR_COUNT_H, r[15:8]);
    rd(WKT_ADDR_COUNT_L, r[7:0]);
    wr(WKT_ADDR_CONTROL, 8'h48);
    ticks(2);
    rd(WKT_ADDR_CONTROL, 8'h08);
    rd(WKT_ADDR_COUNT_L, r[7:0]);
    // each tick source: no underflow one edge early, underflow on the last
    wr(WKT_ADDR_RELOAD_H, 8'h00);
    wr(WKT_ADDR_RELOAD_L, 8'h01);
    for (int s = 0; s < 4; s++) begin
      div = (s == 0) ? 1 : (8 << (s - 1));
      wr(WKT_ADDR_MASK, 8'(s & 1));
      wr(WKT_ADDR_CONTROL, 8'hc0 | 8'(s));
      ticks(2 * div - 1);
      rd(WKT_ADDR_STATUS, 8'h00);
      ticks(1);
      chk("irq", 8'(s & 1), {7'h00, irq});
      rd(WKT_ADDR_STATUS, 8'h01);
      rd(WKT_ADDR_CONTROL, 8'(s));
      repeat (2) @(posedge mclk);
      chk("irq cleared", 8'h00, {7'h00, irq});
    end
    wr(WKT_ADDR_RELOAD_L, 8'h02);
    wr(WKT_ADDR_CONTROL, 8'hc8);
    ticks(3);
    rd(WKT_ADDR_STATUS, 8'h01);
    rd(WKT_ADDR_COUNT_L, 8'h02);
    rd(WKT_ADDR_CONTROL, 8'h88);
    // card probing with calibration and auto-wake, no card then card
    // trim and field-on timers live outside; the done pin stands in for the field-on timer
    wr(WKT_ADDR_RELOAD_L, 8'h00);
    wr(WKT_ADDR_MASK, 8'h06);
    wr(WKT_ADDR_CONTROL, 8'hf4);
    ticks(1);
    chk("trim", 8'h01, 8'(n_trim));
    chk("probe", 8'h01, 8'(n_probe));
    chk("wake", 8'h01, 8'(n_wake));
    chk("field", 8'h01, {7'h00, field});
    rd(WKT_ADDR_CONTROL, 8'hb4);
    done <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("power down", 8'h01, {7'h00, pd});
    chk("field off", 8'h00, {7'h00, field});
    rd(WKT_ADDR_STATUS, 8'h05);
    done <= 1'b0;
    card <= 1'b1;
    ticks(1);
    chk("woken", 8'h00, {7'h00, pd});
    chk("probe again", 8'h02, 8'(n_probe));
    done <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("card irq", 8'h01, {7'h00, irq});
    chk("active", 8'h00, {7'h00, pd});
    rd(WKT_ADDR_STATUS, 8'h03);
    wr(WKT_ADDR_CONTROL, 8'h40);
    done <= 1'b0;
    repeat (4) @(posedge mclk);
    give_verdict();
  end
endmodule : tb_wkt_top
`default_nettype wire

// ===== test/wkt_checker.sv
// wkt_checker: port-level assertions for the wake-up timer
// assumes one mclk domain; bound onto wkt_top
`timescale 1ns/1ps
`default_nettype none
module wkt_checker (
  // clock, reset and read path
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_q,
  // system control outputs
  input wire logic       trim_start_q,
  input wire logic       probe_start_q,
  input wire logic       field_on_q,
  input wire logic       wake_q,
  input wire logic       power_down_q,
  input wire logic       irq_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // read data only in the cycle after a read strobe
  property p_rd_idle; !reg_rd |=> reg_rdata_q == 8'h00; endproperty
  property p_unmapped; reg_rd && reg_addr == 8'h30 |=> reg_rdata_q == 8'h00; endproperty
  property p_trim_pulse; trim_start_q |=> !trim_start_q; endproperty
  property p_probe_pulse; probe_start_q |=> !probe_start_q [*2]; endproperty
  // the field output is registered one cycle behind the start pulse
  property p_field_start; $rose(field_on_q) |-> $past(probe_start_q); endproperty
  property p_probe_field; probe_start_q |=> field_on_q; endproperty
  property p_wake_pulse; wake_q |-> !power_down_q ##1 !wake_q; endproperty
  // power down is left only by a wake or by a probe that ends
  property p_pd_fall; $fell(power_down_q) |-> wake_q || $fell(field_on_q); endproperty
  property p_pd_rise; $rose(power_down_q) |-> !field_on_q; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_trim_pulse: assert property (p_trim_pulse) else $error("trim start too long");
  a_probe_pulse: assert property (p_probe_pulse) else $error("probe start too long");
  a_field_start: assert property (p_field_start) else $error("field on without start");
  a_probe_field: assert property (p_probe_field) else $error("probe without field");
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse wrong");
  a_pd_fall: assert property (p_pd_fall) else $error("power down left wrongly");
  a_pd_rise: assert property (p_pd_rise) else $error("power down with field on");
  c_trim: cover property (trim_start_q);
  c_pd: cover property (power_down_q);
  c_irq: cover property (irq_q);
endmodule : wkt_checker
bind wkt_top wkt_checker u_chk (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .trim_start_q(trim_start_q),
  .probe_start_q(probe_start_q), .field_on_q(field_on_q), .wake_q(wake_q),
  .power_down_q(power_down_q), .irq_q(irq_q));
`default_nettype wire
